// >>> rtl/bpu_cfg.svh
// Constants of the branch and predication unit
`ifndef BPU_CFG_SVH
`define BPU_CFG_SVH
`define BPU_COND_ALWAYS   4'he
`define BPU_REL_SHORT_MAX 32'sh000fffff
`define BPU_REL_SHORT_MIN -32'sh00100000
`define BPU_REL_LONG_MAX  32'sh00ffffff
`define BPU_REL_LONG_MIN  -32'sh01000000
`define BPU_CZ_MIN        32'h00000004
`define BPU_CZ_MAX        32'h00000082
`define BPU_CZ_REG_MAX    4'h7
`define BPU_REG_STACK     4'hd
`define BPU_REG_LINK      4'he
`define BPU_REG_PC        4'hf
`define BPU_SLOTS         3'h4
`endif

// >>> rtl/bpu_cond_eval.sv
// Condition code evaluator
`timescale 1ns/1ns
module bpu_cond_eval (
	input  wire logic [3:0] i_cond,
	input  wire logic [3:0] i_nzcv,
	output logic            o_pass
);
	logic n, z, c, v;
	always_comb begin
		{n, z, c, v} = i_nzcv;
		case (i_cond[3:1])
			3'h0:    o_pass = z;
			3'h1:    o_pass = c;
			3'h2:    o_pass = n;
			3'h3:    o_pass = v;
			3'h4:    o_pass = c & ~z;
			3'h5:    o_pass = n == v;
			3'h6:    o_pass = (n == v) & ~z;
			default: o_pass = 1'b1;
		endcase
		if (i_cond[0] && i_cond != 4'hf) begin
			o_pass = ~o_pass;
		end
		if (i_cond == 4'hf) begin
			o_pass = 1'b1;
		end
	end
endmodule

// >>> rtl/bpu_core.sv
// Branch and predication unit: jumps, calls, table jumps, predication
`timescale 1ns/1ns
`include "bpu_cfg.svh"
module bpu_core (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_valid,
	input  wire bpu_pkg::bpu_instr_t  i_instr,
	input  wire logic [3:0]           i_nzcv,
	input  wire logic                 i_exc_take,
	input  wire logic                 i_exc_return,
	input  wire bpu_pkg::bpu_pred_t   i_saved_pred,
	input  wire logic                 i_tbl_valid,
	input  wire logic [15:0]          i_tbl_data,
	output logic                      o_ready,
	output logic                      o_tbl_req,
	output logic [31:0]               o_tbl_addr,
	output logic                      o_tbl_half,
	output logic                      o_pc_wr,
	output logic [31:0]               o_pc_val,
	output logic                      o_lr_wr,
	output logic [31:0]               o_lr_val,
	output logic                      o_fault,
	output logic                      o_halt,
	output logic                      o_exec,
	output logic [3:0]                o_nzcv,
	output bpu_pkg::bpu_pred_t        o_pred,
	output logic [31:0]               o_exc_ret_addr
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic in_range(input logic signed [31:0] d, input logic wide);
		if (wide) begin
			in_range = d >= `BPU_REL_LONG_MIN && d <= `BPU_REL_LONG_MAX;
		end else begin
			in_range = d >= `BPU_REL_SHORT_MIN && d <= `BPU_REL_SHORT_MAX;
		end
	endfunction

	function automatic logic [31:0] next_addr(input bpu_pkg::bpu_instr_t ins);
		next_addr = ins.pc + {29'h0, ins.len, 1'b0};
	endfunction

	// ****************************************************************
	// Condition selection
	// ****************************************************************
	bpu_pkg::bpu_pred_t pred_ff, nxt_pred;
	bpu_pkg::bpu_state_t st_ff, nxt_st;
	logic [31:0] tbl_next_ff, nxt_tbl_next;
	logic        in_block, slot_else, cond_pass, cmp_pass;
	logic [3:0]  eff_cond;
	logic [31:0] nxt_addr, disp_t;

	assign in_block  = pred_ff.left != 3'h0;
	assign slot_else = pred_ff.mask[3];
	always_comb begin
		if (in_block) begin
			eff_cond = slot_else ? {pred_ff.base[3:1], ~pred_ff.base[0]} : pred_ff.base;
		end else begin
			eff_cond = i_instr.cond;
		end
	end

	bpu_cond_eval u_cond (
		.i_cond (eff_cond),
		.i_nzcv (i_nzcv),
		.o_pass (cond_pass)
	);

	// ****************************************************************
	// Execution
	// ****************************************************************
	always_comb begin
		nxt_pred     = pred_ff;
		nxt_st       = st_ff;
		nxt_tbl_next = tbl_next_ff;
		o_pc_wr      = 1'b0;
		o_pc_val     = 32'h0;
		o_lr_wr      = 1'b0;
		o_lr_val     = 32'h0;
		o_fault      = 1'b0;
		o_halt       = 1'b0;
		o_exec       = 1'b0;
		o_tbl_req    = 1'b0;
		o_tbl_addr   = 32'h0;
		o_tbl_half   = 1'b0;
		nxt_addr     = next_addr(i_instr);
		disp_t       = 32'h0;
		cmp_pass     = 1'b0;
		o_ready      = st_ff == bpu_pkg::BPU_ST_IDLE;
		case (st_ff)
			bpu_pkg::BPU_ST_IDLE: begin
				if (i_exc_take) begin
					o_ready  = 1'b0;
					// Handler runs unconditionally; progress lives in o_pred
					nxt_pred = '0;
				end else if (i_exc_return) begin
					nxt_pred = i_saved_pred;
				end else if (i_valid) begin
					// Prefix condition is the base of its block, never a gate
					o_exec = cond_pass || i_instr.op == bpu_pkg::BPU_OP_HALT ||
						i_instr.op == bpu_pkg::BPU_OP_PRED;
					if (in_block) begin
						nxt_pred.mask = {pred_ff.mask[2:0], 1'b0};
						nxt_pred.left = pred_ff.left - 3'h1;
					end
					if (o_exec) begin
						case (i_instr.op)
							bpu_pkg::BPU_OP_JREL, bpu_pkg::BPU_OP_CALLR: begin
								if (in_range(i_instr.imm, 1'b1)) begin
									o_pc_wr  = 1'b1;
									o_pc_val = i_instr.pc + 32'h4 + i_instr.imm;
								end else begin
									o_fault = 1'b1;
								end
								if (i_instr.op == bpu_pkg::BPU_OP_CALLR) begin
									o_lr_wr  = 1'b1;
									o_lr_val = nxt_addr;
								end
							end
							bpu_pkg::BPU_OP_JCREL: begin
								if (in_range(i_instr.imm, in_block)) begin
									o_pc_wr  = 1'b1;
									o_pc_val = i_instr.pc + 32'h4 + i_instr.imm;
								end else begin
									o_fault = 1'b1;
								end
							end
							bpu_pkg::BPU_OP_JIND, bpu_pkg::BPU_OP_CALLI: begin
								if (!i_instr.rn_val[0]) begin
									o_fault = 1'b1;
								end else begin
									o_pc_wr  = 1'b1;
									o_pc_val = {i_instr.rn_val[31:1], 1'b0};
									if (i_instr.op == bpu_pkg::BPU_OP_CALLI) begin
										o_lr_wr  = 1'b1;
										o_lr_val = nxt_addr;
									end
								end
							end
							bpu_pkg::BPU_OP_CZ, bpu_pkg::BPU_OP_CNZ: begin
								cmp_pass = (i_instr.rn_val == 32'h0) ==
									(i_instr.op == bpu_pkg::BPU_OP_CZ);
								if (i_instr.rn > `BPU_CZ_REG_MAX || i_instr.imm < `BPU_CZ_MIN ||
									i_instr.imm > `BPU_CZ_MAX || in_block) begin
									o_fault = 1'b1;
								end else if (cmp_pass) begin
									o_pc_wr  = 1'b1;
									o_pc_val = i_instr.pc + i_instr.imm;
								end
							end
							bpu_pkg::BPU_OP_TBYTE, bpu_pkg::BPU_OP_THALF: begin
								o_tbl_req  = 1'b1;
								o_tbl_half = i_instr.op == bpu_pkg::BPU_OP_THALF;
								disp_t     = o_tbl_half ? {i_instr.rm_val[30:0], 1'b0}
									: i_instr.rm_val;
								o_tbl_addr = (i_instr.rn == `BPU_REG_PC ? nxt_addr
									: i_instr.rn_val) + disp_t;
								nxt_tbl_next = nxt_addr;
								nxt_st       = bpu_pkg::BPU_ST_TABLE;
							end
							bpu_pkg::BPU_OP_PRED: begin
								if (in_block) begin
									o_fault = 1'b1;
								end else begin
									nxt_pred.base = i_instr.cond;
									nxt_pred.left = i_instr.mask[0] ? `BPU_SLOTS : i_instr.mask[1] ?
										3'h3 : i_instr.mask[2] ? 3'h2 : 3'h1;
									nxt_pred.mask = {1'b0, i_instr.mask[3:1]};
								end
							end
							bpu_pkg::BPU_OP_HALT: begin
								o_halt = 1'b1;
							end
							default: begin
							end
						endcase
					end
				end
			end
			bpu_pkg::BPU_ST_TABLE: begin
				o_tbl_req = 1'b0;
				if (i_tbl_valid) begin
					o_pc_wr  = 1'b1;
					o_pc_val = tbl_next_ff + {15'h0, i_tbl_data, 1'b0};
					nxt_st   = bpu_pkg::BPU_ST_IDLE;
				end
			end
			default: begin
				nxt_st = bpu_pkg::BPU_ST_IDLE;
			end
		endcase
		o_nzcv = i_nzcv;
	end

	assign o_pred         = pred_ff;
	assign o_exc_ret_addr = i_instr.pc;

	// ****************************************************************
	// State registers
	// ****************************************************************
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pred_ff     <= '0;
			st_ff       <= bpu_pkg::BPU_ST_IDLE;
			tbl_next_ff <= 32'h0;
		end else begin
			pred_ff     <= nxt_pred;
			st_ff       <= nxt_st;
			tbl_next_ff <= nxt_tbl_next;
		end
	end
endmodule

// >>> rtl/bpu_pkg.sv
// Types of the branch and predication unit
package bpu_pkg;
	typedef enum logic [3:0] {
		BPU_OP_NONE   = 4'h0,
		BPU_OP_JREL   = 4'h1,
		BPU_OP_JCREL  = 4'h2,
		BPU_OP_CALLR  = 4'h3,
		BPU_OP_JIND   = 4'h4,
		BPU_OP_CALLI  = 4'h5,
		BPU_OP_CZ     = 4'h6,
		BPU_OP_CNZ    = 4'h7,
		BPU_OP_TBYTE  = 4'h8,
		BPU_OP_THALF  = 4'h9,
		BPU_OP_PRED   = 4'ha,
		BPU_OP_HALT   = 4'hb,
		BPU_OP_OTHER  = 4'hc
	} bpu_op_t;
	typedef struct packed {
		bpu_op_t     op;
		logic [3:0]  cond;
		logic [3:0]  mask;
		logic [3:0]  rn;
		logic [31:0] rn_val;
		logic [31:0] rm_val;
		logic [31:0] imm;
		logic [31:0] pc;
		logic [1:0]  len;
	} bpu_instr_t;
	typedef struct packed {
		logic [3:0] base;
		logic [3:0] mask;
		logic [2:0] left;
	} bpu_pred_t;
	typedef enum logic [2:0] {
		BPU_ST_IDLE  = 3'b001,
		BPU_ST_TABLE = 3'b010,
		BPU_ST_DONE  = 3'b100
	} bpu_state_t;
endpackage

// >>> testbench/bpu_core_assertions.sv
// Port assertions of the branch and predication unit
`timescale 1ns/1ns
module bpu_core_assertions (
	input wire logic                i_core_clk,
	input wire logic                i_rst,
	input wire logic                i_valid,
	input wire bpu_pkg::bpu_instr_t i_instr,
	input wire logic                i_exc_take,
	input wire logic                i_tbl_valid,
	input wire logic                o_ready,
	input wire logic                o_tbl_req,
	input wire logic                o_pc_wr,
	input wire logic                o_lr_wr,
	input wire logic [31:0]         o_lr_val,
	input wire logic                o_fault,
	input wire logic                o_halt,
	input wire bpu_pkg::bpu_pred_t  o_pred
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_rst);
wire       tk  = i_valid && o_ready;
wire       out = o_pred.left == 3'h0;
wire [3:0] op  = i_instr.op;
wire [3:0] m   = i_instr.mask;
wire [2:0] lft = o_pred.left;
wire [2:0] cnt = m[0] ? 3'h4 : m[1] ? 3'h3 : m[2] ? 3'h2 : 3'h1;
sequence tbl_s;
	tk && out && (op == bpu_pkg::BPU_OP_TBYTE || op == bpu_pkg::BPU_OP_THALF);
endsequence
sequence tbl_done_s;
	i_tbl_valid && o_pc_wr;
endsequence
tbl_answer_a: assert property (tbl_s |-> o_tbl_req ##1 !o_ready ##[0:7] tbl_done_s)
	else $error("table jump not completed");
ind_fault_a: assert property (tk && out && (op == bpu_pkg::BPU_OP_JIND ||
	op == bpu_pkg::BPU_OP_CALLI) && !i_instr.rn_val[0] && !i_instr.rm_val[0]
	|-> o_fault && !o_pc_wr) else $error("even target did not fault");
call_link_a: assert property (tk && out && op == bpu_pkg::BPU_OP_CALLR && !o_fault
	|-> o_lr_wr && o_lr_val == i_instr.pc + {29'h0, i_instr.len, 1'b0})
	else $error("call return address wrong");
cz_reg_a: assert property (tk && (op == bpu_pkg::BPU_OP_CZ ||
	op == bpu_pkg::BPU_OP_CNZ) && i_instr.rn > 4'h7 |-> o_fault)
	else $error("high register accepted");
rel_short_a: assert property (tk && out && op == bpu_pkg::BPU_OP_JCREL &&
	$signed(i_instr.imm) > 32'sh000fffff |-> !o_pc_wr) else $error("short range exceeded");
pred_count_a: assert property (tk && out && op == bpu_pkg::BPU_OP_PRED && !o_fault
	|=> lft == $past(cnt)) else $error("block length wrong");
pred_step_a: assert property (tk && !out && !i_exc_take |=> lft == $past(lft) - 3'h1)
	else $error("block progress wrong");
halt_always_a: assert property (tk && op == bpu_pkg::BPU_OP_HALT |-> o_halt)
	else $error("halt skipped");
exc_refuse_a: assert property (i_exc_take |-> !o_ready)
	else $error("request taken during exception");
endmodule
bind bpu_core bpu_core_assertions i_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_valid(i_valid), .i_instr(i_instr), .i_exc_take(i_exc_take), .i_tbl_valid(i_tbl_valid),
	.o_ready(o_ready), .o_tbl_req(o_tbl_req), .o_pc_wr(o_pc_wr), .o_lr_wr(o_lr_wr),
	.o_lr_val(o_lr_val), .o_fault(o_fault), .o_halt(o_halt), .o_pred(o_pred));

// >>> testbench/bpu_tbl_mem.sv
// Table memory answering table jump lookups
`timescale 1ns/1ns
module bpu_tbl_mem (
	input  wire logic        i_core_clk,
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	input  wire logic        i_half,
	output logic             o_valid,
	output logic [15:0]      o_data
);
initial o_valid = 1'b0;
initial o_data = 16'h0;
// Idle data toggles so a stale entry is never mistaken for an answer
always @(posedge i_core_clk) begin
	o_valid <= i_req;
	o_data <= !i_req ? ~o_data : i_half ? {i_addr[7:0], 8'h21} : {8'h0, i_addr[7:0]};
end
endmodule

// >>> testbench/test_branch_and_predication_unit.sv
// Self-checking bench of the branch and predication unit
`timescale 1ns/1ns
module test_branch_and_predication_unit;
logic clk = 1'b0, rst = 1'b1, vld = 1'b0, et = 1'b0, er = 1'b0;
logic tv, rdy, tq, th, pw, lw, flt, hlt, ex;
logic [3:0] nz = 4'h4, onz;
logic [15:0] td;
logic [31:0] ta, pv, lv, ra;
bpu_pkg::bpu_instr_t ins = '0;
bpu_pkg::bpu_pred_t sp = '0, pr, sv;
int num_errors = 0, compares = 0;
always #25 clk = ~clk;
bpu_core i_dut (.i_core_clk(clk), .i_rst(rst), .i_valid(vld), .i_instr(ins), .i_nzcv(nz),
	.i_exc_take(et), .i_exc_return(er), .i_saved_pred(sp), .i_tbl_valid(tv), .i_tbl_data(td),
	.o_ready(rdy), .o_tbl_req(tq), .o_tbl_addr(ta), .o_tbl_half(th), .o_pc_wr(pw),
	.o_pc_val(pv), .o_lr_wr(lw), .o_lr_val(lv), .o_fault(flt), .o_halt(hlt), .o_exec(ex),
	.o_nzcv(onz), .o_pred(pr), .o_exc_ret_addr(ra));
bpu_tbl_mem i_mem (.i_core_clk(clk), .i_req(tq), .i_addr(ta), .i_half(th), .o_valid(tv),
	.o_data(td));
task complete_run;
	$display("errors %0d compares %0d", num_errors, compares);
	if (num_errors == 0 && compares > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
task chk(input logic [31:0] g, e);
	compares++;
	if (g !== e) begin
		num_errors++;
		$display("[FAIL] %0t got %h exp %h", $time, g, e);
	end
endtask
task iss(input bpu_pkg::bpu_op_t op, input logic [31:0] imm = 0, input logic [3:0] c = 4'he,
	input logic [31:0] rv = 0, mv = 0, input logic [3:0] rn = 0, m = 0);
	@(posedge clk);
	vld <= 1'b1;
	ins <= '{op, c, m, rn, rv, mv, imm, 32'h1000, 2'h2};
	#5;
	chk(onz, nz);
endtask
task t_rel;
	iss(bpu_pkg::BPU_OP_JREL, 32'h00fffffe);
	chk(pv, 32'h01001002);
	iss(bpu_pkg::BPU_OP_JREL, 32'hff000000);
	chk(pv, 32'hff001004);
	iss(bpu_pkg::BPU_OP_CALLR);
	chk(lv, 32'h1004);
	iss(bpu_pkg::BPU_OP_JCREL, 32'h000ffffe, 4'h0);
	chk(pv, 32'h00101002);
	iss(bpu_pkg::BPU_OP_JCREL, 32'h00100000, 4'h0);
	chk(flt, 1);
endtask
task t_ind;
	iss(bpu_pkg::BPU_OP_JIND, 0, 4'he, 32'h2001, 32'h2001);
	chk(pv, 32'h2000);
	iss(bpu_pkg::BPU_OP_CALLI, 0, 4'he, 32'h2001, 32'h2001);
	chk(lv, 32'h1004);
	iss(bpu_pkg::BPU_OP_JIND, 0, 4'he, 32'h2000, 32'h2000);
	chk(flt, 1);
	chk(pw, 0);
endtask
task t_cz;
	iss(bpu_pkg::BPU_OP_CZ, 32'h82, 4'he, 0, 0, 4'h7);
	chk(pv, 32'h1082);
	iss(bpu_pkg::BPU_OP_CNZ, 32'h4, 4'he, 0, 0, 4'h7);
	chk(pw, 0);
	iss(bpu_pkg::BPU_OP_CNZ, 32'h4, 4'he, 5, 5);
	chk(pv, 32'h1004);
	iss(bpu_pkg::BPU_OP_CZ, 32'h4, 4'he, 0, 0, 4'h8);
	chk(flt, 1);
	iss(bpu_pkg::BPU_OP_CZ, 32'h84);
	chk(flt, 1);
endtask
task t_tbl;
	iss(bpu_pkg::BPU_OP_TBYTE, 0, 4'he, 0, 3, 4'hf);
	chk(ta, 32'h1007);
	@(posedge clk);
	#5;
	chk(pv, 32'h1012);
	iss(bpu_pkg::BPU_OP_THALF, 0, 4'he, 32'h2000, 3, 4'h2);
	chk(ta, 32'h2006);
	@(posedge clk);
	#5;
	chk(pv, 32'h1c46);
endtask
task t_pred;
	iss(bpu_pkg::BPU_OP_PRED, 0, 4'h0, 0, 0, 0, 4'h7);
	iss(bpu_pkg::BPU_OP_OTHER, 0, 4'h0);
	chk(pr.left, 4);
	iss(bpu_pkg::BPU_OP_OTHER, 0, 4'h0);
	chk(ex, 1);
	@(posedge clk);
	vld <= 1'b0;
	et <= 1'b1;
	#5;
	chk(ra, 32'h1000);
	sv = pr;
	@(posedge clk);
	et <= 1'b0;
	er <= 1'b1;
	sp <= sv;
	#5;
	chk(pr.left, 0);
	@(posedge clk);
	er <= 1'b0;
	iss(bpu_pkg::BPU_OP_OTHER, 0, 4'h1);
	chk(ex, 0);
	chk(pr.left, 2);
	iss(bpu_pkg::BPU_OP_HALT, 0, 4'h1);
	chk(hlt, 1);
	iss(bpu_pkg::BPU_OP_OTHER);
	chk(ex, 1);
	chk(pr.left, 0);
	iss(bpu_pkg::BPU_OP_PRED, 0, 4'h1, 0, 0, 0, 4'h8);
	iss(bpu_pkg::BPU_OP_OTHER, 0, 4'h1);
	chk(pr.left, 1);
	chk(ex, 0);
	iss(bpu_pkg::BPU_OP_PRED, 0, 4'h0, 0, 0, 0, 4'h8);
	iss(bpu_pkg::BPU_OP_JCREL, 32'h00100000, 4'h0);
	chk(pv, 32'h00101004);
	chk(flt, 0);
endtask
initial begin
	repeat (4) @(posedge clk);
	rst <= 1'b0;
	t_rel;
	t_ind;
	t_cz;
	t_tbl;
	t_pred;
	complete_run;
end
initial begin
	repeat (500) @(posedge clk);
	num_errors++;
	complete_run;
end
endmodule
